//--- design/ortsm_marker.sv
`timescale 1ns/1ps
module ortsm_marker #(
    parameter int LAT = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic marker_input,
    input wire logic [11:0] rise_sample,
    input wire logic [11:0] fall_sample,
    output logic marker_q,
    output logic [11:0] rise_q,
    output logic [11:0] fall_q
);
    // Marker is resynchronised; the sample path is delayed by the same stages
    // so the marked sample is the one taken alongside the trigger.
    logic [LAT-1:0] mark_pipe_reg;
    logic [11:0] rise_pipe_reg [LAT];
    logic [11:0] fall_pipe_reg [LAT];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mark_pipe_reg <= '0;
        end else begin
            mark_pipe_reg <= {mark_pipe_reg[LAT-2:0], marker_input};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < LAT; i++) begin
                rise_pipe_reg[i] <= 12'h000;
                fall_pipe_reg[i] <= 12'h000;
            end
        end else begin
            rise_pipe_reg[0] <= rise_sample;
            fall_pipe_reg[0] <= fall_sample;
            for (int i = 1; i < LAT; i++) begin
                rise_pipe_reg[i] <= rise_pipe_reg[i-1];
                fall_pipe_reg[i] <= fall_pipe_reg[i-1];
            end
        end
    end

    assign marker_q = mark_pipe_reg[LAT-1];
    assign rise_q = rise_pipe_reg[LAT-1];
    assign fall_q = fall_pipe_reg[LAT-1];
endmodule

//--- design/ortsm_ovr_mon.sv
`timescale 1ns/1ps
module ortsm_ovr_mon (
    input wire logic core_clk,
    input wire logic rst,
    ortsm_ovr_if.mon bus
);
    import ortsm_pkg::*;

    logic [7:0] mag;
    logic hit_hi;
    logic hit_lo;
    logic [ORTSM_PULSE_W-1:0] pulse_len;
    logic [ORTSM_WIN_W-1:0] win_len;
    logic [ORTSM_PULSE_W-1:0] cnt_hi_reg;
    logic [ORTSM_PULSE_W-1:0] cnt_lo_reg;
    logic [ORTSM_WIN_W-1:0] win_reg;
    logic acc_hi_reg;
    logic acc_lo_reg;
    logic emb_hi_reg;
    logic emb_lo_reg;

    assign mag = ortsm_abs_top8(bus.sample);
    assign hit_hi = bus.sample_valid && (mag >= bus.high_level_threshold);
    assign hit_lo = bus.sample_valid && (mag >= bus.low_level_threshold);
    assign pulse_len = ORTSM_PULSE_W'(ORTSM_PULSE_BASE)
        << bus.overrange_hold_select;
    assign win_len = ORTSM_WIN_W'(1) << bus.overrange_hold_select;

    // ==========================================================
    // Stretched status: restarts on every event, so length counts from the last one
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_hi_reg <= '0;
            cnt_lo_reg <= '0;
        end else begin
            if (hit_hi) begin
                cnt_hi_reg <= pulse_len;
            end else if (cnt_hi_reg != '0) begin
                cnt_hi_reg <= cnt_hi_reg - 1'b1;
            end
            if (hit_lo) begin
                cnt_lo_reg <= pulse_len;
            end else if (cnt_lo_reg != '0) begin
                cnt_lo_reg <= cnt_lo_reg - 1'b1;
            end
        end
    end

    // ==========================================================
    // Embedded flags: result of the last complete window of converter samples
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            win_reg <= '0;
            acc_hi_reg <= 1'b0;
            acc_lo_reg <= 1'b0;
            emb_hi_reg <= 1'b0;
            emb_lo_reg <= 1'b0;
        end else if (bus.sample_valid) begin
            if (win_reg + 1'b1 >= win_len) begin
                win_reg <= '0;
                emb_hi_reg <= acc_hi_reg | hit_hi;
                emb_lo_reg <= acc_lo_reg | hit_lo;
                acc_hi_reg <= 1'b0;
                acc_lo_reg <= 1'b0;
            end else begin
                win_reg <= win_reg + 1'b1;
                acc_hi_reg <= acc_hi_reg | hit_hi;
                acc_lo_reg <= acc_lo_reg | hit_lo;
            end
        end
    end

    assign bus.pulse_hi = cnt_hi_reg != '0;
    assign bus.pulse_lo = cnt_lo_reg != '0;
    assign bus.emb_hi = emb_hi_reg;
    assign bus.emb_lo = emb_lo_reg;
endmodule

//--- design/ortsm_top.sv
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
module ortsm_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [11:0] conv_rise_sample,
    input wire logic [11:0] conv_fall_sample,
    input wire logic marker_input,
    input wire logic ddc_valid,
    input wire logic [15:0] ddc_a_i,
    input wire logic [15:0] ddc_a_q,
    input wire logic [15:0] ddc_b_i,
    input wire logic [15:0] ddc_b_q,
    input wire logic sysref_in,
    output logic chan_a_high_flag_out,
    output logic chan_a_low_flag_out,
    output logic chan_b_high_flag_out,
    output logic chan_b_low_flag_out,
    output logic [11:0] out_rise_sample,
    output logic [11:0] out_fall_sample,
    output logic out_cplx_valid,
    output logic [15:0] out_a_i,
    output logic [15:0] out_a_q,
    output logic [15:0] out_b_i,
    output logic [15:0] out_b_q,
    output logic sysref_capture,
    output ortsm_pkg::ortsm_mode_t link_mode_select
);
    import ortsm_pkg::*;

    logic timestamp_en_reg;
    logic single_chan_reg;
    logic byte_mode_reg;
    ortsm_mode_t mode_reg;
    logic [2:0] hold_reg;
    logic [7:0] thr_hi_reg;
    logic [7:0] thr_lo_reg;
    logic sysref_q_reg;
    logic sysref_prev_reg;
    logic [15:0] sysref_cnt_reg;
    logic ts_active;
    logic marker_q;
    logic [11:0] rise_q;
    logic [11:0] fall_q;
    logic [31:0] status_word;

    ortsm_ovr_if mon_a ();
    ortsm_ovr_if mon_b ();

    // ==========================================================
    // Register bus
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            timestamp_en_reg <= ORTSM_CTRL_RST[ORTSM_CTRL_TS_EN_BIT];
            single_chan_reg <= ORTSM_CTRL_RST[ORTSM_CTRL_SINGLE_BIT];
            byte_mode_reg <= ORTSM_CTRL_RST[ORTSM_CTRL_BYTE_BIT];
            mode_reg <= ORTSM_CTRL_RST[ORTSM_CTRL_MODE_LSB +: 4];
        end else if (reg_wr && reg_addr == ORTSM_ADDR_CTRL) begin
            timestamp_en_reg <= reg_wdata[ORTSM_CTRL_TS_EN_BIT];
            single_chan_reg <= reg_wdata[ORTSM_CTRL_SINGLE_BIT];
            byte_mode_reg <= reg_wdata[ORTSM_CTRL_BYTE_BIT];
            mode_reg <= reg_wdata[ORTSM_CTRL_MODE_LSB +: 4];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hold_reg <= ORTSM_HOLD_RST;
            thr_hi_reg <= ORTSM_THR_HI_RST;
            thr_lo_reg <= ORTSM_THR_LO_RST;
        end else if (reg_wr) begin
            if (reg_addr == ORTSM_ADDR_OVR_CFG) begin
                hold_reg <= reg_wdata[2:0];
            end
            if (reg_addr == ORTSM_ADDR_THRESH) begin
                thr_hi_reg <= reg_wdata[ORTSM_THR_HI_LSB +: 8];
                thr_lo_reg <= reg_wdata[ORTSM_THR_LO_LSB +: 8];
            end
        end
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ORTSM_STAT_PULSE_LSB +: 4] = {chan_b_low_flag_out, chan_b_high_flag_out,
                                                  chan_a_low_flag_out, chan_a_high_flag_out};
        status_word[ORTSM_STAT_EMB_LSB +: 4] = {mon_b.emb_lo, mon_b.emb_hi,
                                                mon_a.emb_lo, mon_a.emb_hi};
        status_word[ORTSM_STAT_TS_BIT] = ts_active;
        status_word[ORTSM_STAT_SREF_LSB +: 16] = sysref_cnt_reg;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                ORTSM_ADDR_CTRL: begin
                    reg_rdata <= {24'h000000, mode_reg, 1'b0, byte_mode_reg,
                                  single_chan_reg, timestamp_en_reg};
                end
                ORTSM_ADDR_OVR_CFG: begin
                    reg_rdata <= {29'h00000000, hold_reg};
                end
                ORTSM_ADDR_THRESH: begin
                    reg_rdata <= {16'h0000, thr_lo_reg, thr_hi_reg};
                end
                ORTSM_ADDR_STATUS: begin
                    reg_rdata <= status_word;
                end
                default: begin
                    reg_rdata <= 32'h0000_0000;
                end
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ==========================================================
    // Overrange monitors: in every mode, single-channel or not, channel B watches the
    // falling-edge samples, so each threshold appears on two outputs.
    assign mon_a.overrange_hold_select = hold_reg;
    assign mon_a.high_level_threshold = thr_hi_reg;
    assign mon_a.low_level_threshold = thr_lo_reg;
    assign mon_a.sample = conv_rise_sample;
    assign mon_a.sample_valid = 1'b1;
    assign mon_b.overrange_hold_select = hold_reg;
    assign mon_b.high_level_threshold = thr_hi_reg;
    assign mon_b.low_level_threshold = thr_lo_reg;
    assign mon_b.sample = conv_fall_sample;
    assign mon_b.sample_valid = 1'b1;

    ortsm_ovr_mon u_mon_a (
        .core_clk(core_clk),
        .rst(rst),
        .bus(mon_a)
    );

    ortsm_ovr_mon u_mon_b (
        .core_clk(core_clk),
        .rst(rst),
        .bus(mon_b)
    );

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chan_a_high_flag_out <= 1'b0;
            chan_a_low_flag_out <= 1'b0;
            chan_b_high_flag_out <= 1'b0;
            chan_b_low_flag_out <= 1'b0;
        end else begin
            chan_a_high_flag_out <= mon_a.pulse_hi;
            chan_a_low_flag_out <= mon_a.pulse_lo;
            chan_b_high_flag_out <= mon_b.pulse_hi;
            chan_b_low_flag_out <= mon_b.pulse_lo;
        end
    end

    // ==========================================================
    // Complex samples carry the embedded flags in their LSB
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out_cplx_valid <= 1'b0;
            out_a_i <= 16'h0000;
            out_a_q <= 16'h0000;
            out_b_i <= 16'h0000;
            out_b_q <= 16'h0000;
        end else begin
            out_cplx_valid <= ddc_valid && ortsm_mode_decim(mode_reg);
            if (ddc_valid) begin
                out_a_i <= {ddc_a_i[15:1], mon_a.emb_hi};
                out_a_q <= {ddc_a_q[15:1], mon_a.emb_lo};
                out_b_i <= {ddc_b_i[15:1], mon_b.emb_hi};
                out_b_q <= {ddc_b_q[15:1], mon_b.emb_lo};
            end
        end
    end

    // ==========================================================
    // Timestamp marking
    assign ts_active = timestamp_en_reg && !ortsm_mode_decim(mode_reg);

    ortsm_marker #(
        .LAT(ORTSM_MARK_LAT)
    ) u_marker (
        .core_clk(core_clk),
        .rst(rst),
        .marker_input(marker_input),
        .rise_sample(conv_rise_sample),
        .fall_sample(conv_fall_sample),
        .marker_q(marker_q),
        .rise_q(rise_q),
        .fall_q(fall_q)
    );

    // Both samples of a clock share one marker sample; finer marking than
    // one device clock is not resolved here.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out_rise_sample <= 12'h000;
            out_fall_sample <= 12'h000;
        end else if (!ts_active) begin
            out_rise_sample <= rise_q;
            out_fall_sample <= single_chan_reg ? fall_q : fall_q;
        end else if (byte_mode_reg) begin
            out_rise_sample <= {rise_q[11:5], marker_q, 4'h0};
            out_fall_sample <= {fall_q[11:5], marker_q, 4'h0};
        end else begin
            out_rise_sample <= {rise_q[11:1], marker_q};
            out_fall_sample <= {fall_q[11:1], marker_q};
        end
    end

    // ==========================================================
    // Reference capture, all on core_clk rising edge
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sysref_q_reg <= 1'b0;
            sysref_prev_reg <= 1'b0;
            sysref_capture <= 1'b0;
            sysref_cnt_reg <= 16'h0000;
        end else begin
            sysref_q_reg <= sysref_in;
            sysref_prev_reg <= sysref_q_reg;
            sysref_capture <= sysref_q_reg && !sysref_prev_reg;
            if (sysref_q_reg && !sysref_prev_reg) begin
                sysref_cnt_reg <= sysref_cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            link_mode_select <= 4'h0;
        end else begin
            link_mode_select <= mode_reg;
        end
    end
endmodule

//--- dv/ortsm_rx_model.sv
`timescale 1ns/1ps
module ortsm_rx_model #(
    parameter int SREF_DIV = 40,
    parameter int QUIET_LEN = 64
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sref_en,
    input wire logic single_chan,
    input wire logic a_hi,
    input wire logic a_lo,
    input wire logic b_hi,
    input wire logic b_lo,
    output logic sysref_out,
    output logic or_hi,
    output logic or_lo,
    output logic gain_up
);
    int sref_cnt;
    int quiet_cnt;
    // ==========================================================
    // Periodic reference, one high cycle every SREF_DIV clocks
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sref_cnt <= 0;
            sysref_out <= 1'b0;
        end else if (sref_en) begin
            sref_cnt <= (sref_cnt == SREF_DIV - 1) ? 0 : sref_cnt + 1;
            sysref_out <= (sref_cnt == 0);
        end else begin
            sref_cnt <= 0;
            sysref_out <= 1'b0;
        end
    end
    // ==========================================================
    // Gain control: quiet low flag for long enough asks for more gain
    assign or_hi = single_chan ? (a_hi | b_hi) : a_hi;
    assign or_lo = single_chan ? (a_lo | b_lo) : a_lo;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            quiet_cnt <= 0;
        end else if (or_lo) begin
            quiet_cnt <= 0;
        end else if (quiet_cnt < QUIET_LEN) begin
            quiet_cnt <= quiet_cnt + 1;
        end
    end
    assign gain_up = (quiet_cnt == QUIET_LEN);
endmodule

//--- dv/ortsm_top_asserts.sv
`timescale 1ns/1ps
module ortsm_top_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [11:0] conv_rise_sample,
    input wire logic ddc_valid,
    input wire logic [15:0] ddc_a_i,
    input wire logic [15:0] ddc_b_q,
    input wire logic sysref_in,
    input wire logic chan_a_high_flag_out,
    input wire logic chan_a_low_flag_out,
    input wire logic chan_b_high_flag_out,
    input wire logic [11:0] out_rise_sample,
    input wire logic out_cplx_valid,
    input wire logic [15:0] out_a_i,
    input wire logic [15:0] out_b_q,
    input wire logic sysref_capture,
    input wire ortsm_pkg::ortsm_mode_t link_mode_select
);
    import ortsm_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [3:0] dec_hist;
    // Decimating mode must have held through the whole sample pipeline
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dec_hist <= 4'h0;
        end else begin
            dec_hist <= {dec_hist[2:0], link_mode_select[3]};
        end
    end
    // ==========================================================
    // Assertions
    a_sysref_edge: assert property ($rose(sysref_in) |-> ##2 sysref_capture)
        else $error("reference capture missing");
    a_capture_single: assert property (sysref_capture |=> !sysref_capture)
        else $error("reference capture longer than one cycle");
    a_ahi_stretch: assert property ($rose(chan_a_high_flag_out)
        |-> chan_a_high_flag_out[*8])
        else $error("channel a high flag too short");
    a_alo_stretch: assert property ($rose(chan_a_low_flag_out)
        |-> chan_a_low_flag_out[*8])
        else $error("channel a low flag too short");
    a_bhi_stretch: assert property ($rose(chan_b_high_flag_out)
        |-> chan_b_high_flag_out[*8])
        else $error("channel b high flag too short");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read answer");
    a_cplx_cause: assert property (out_cplx_valid |-> $past(ddc_valid))
        else $error("complex valid without input");
    a_cplx_data: assert property (out_cplx_valid
        |-> (out_a_i >> 1) == ($past(ddc_a_i) >> 1)
        && (out_b_q >> 1) == ($past(ddc_b_q) >> 1))
        else $error("complex upper bits altered");
    a_ts_off_decim: assert property (link_mode_select[3] && &dec_hist
        |-> out_rise_sample == $past(conv_rise_sample, 3))
        else $error("sample altered in decimating mode");
    c_capture: cover property (sysref_capture);
    c_cplx: cover property (out_cplx_valid && !out_a_i[0]);
    c_flag_end: cover property ($fell(chan_a_high_flag_out));
    c_decim: cover property (&dec_hist);
endmodule
bind ortsm_top ortsm_top_chk u_chk (.core_clk, .rst, .reg_rd, .reg_rdata, .conv_rise_sample,
    .ddc_valid, .ddc_a_i, .ddc_b_q, .sysref_in, .chan_a_high_flag_out, .chan_a_low_flag_out,
    .chan_b_high_flag_out, .out_rise_sample, .out_cplx_valid, .out_a_i, .out_b_q,
    .sysref_capture, .link_mode_select);

//--- dv/tb_overrange_timestamp_sample_marking.sv
`timescale 1ns/1ps
module tb_overrange_timestamp_sample_marking;
    import ortsm_pkg::*;
    typedef struct {
        logic [7:0] ctrl;
        logic [11:0] rise;
        logic [11:0] fall;
        logic mark;
        logic [11:0] e_rise;
        logic [11:0] e_fall;
    } ortsm_row_t;
    ortsm_row_t rows [6] = '{
        '{8'h00, 12'hABC, 12'h123, 1'b1, 12'hABC, 12'h123},
        '{8'h01, 12'hABC, 12'h123, 1'b1, 12'hABD, 12'h123},
        '{8'h03, 12'hABD, 12'h123, 1'b0, 12'hABC, 12'h122},
        '{8'h05, 12'hABC, 12'h123, 1'b1, 12'hAB0, 12'h130},
        '{8'h05, 12'hABC, 12'h123, 1'b0, 12'hAA0, 12'h120},
        '{8'h81, 12'hABC, 12'h123, 1'b1, 12'hABC, 12'h123}};
    logic [11:0] thr_s [6] = '{12'h720, 12'h71F, 12'h8E0, 12'h800, 12'h200, 12'h1FF};
    logic [1:0] thr_e [6] = '{2'h3, 2'h1, 2'h3, 2'h3, 2'h1, 2'h0};
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [11:0] conv_rise_sample = 12'h000;
    logic [11:0] conv_fall_sample = 12'h000;
    logic marker_input = 1'b0;
    logic ddc_valid = 1'b0;
    logic [15:0] ddc_a_i = 16'h0;
    logic [15:0] ddc_a_q = 16'h0;
    logic [15:0] ddc_b_i = 16'h0;
    logic [15:0] ddc_b_q = 16'h0;
    logic sref_en = 1'b0;
    logic sysref_in, sysref_capture, sref_d, gain_up, out_cplx_valid;
    logic chan_a_high_flag_out, chan_a_low_flag_out, chan_b_high_flag_out, chan_b_low_flag_out;
    logic [31:0] reg_rdata, d;
    logic [11:0] out_rise_sample, out_fall_sample;
    logic [15:0] out_a_i, out_a_q, out_b_i, out_b_q;
    ortsm_mode_t link_mode_select;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    int rises = 0;
    int caps = 0;
    int n, m;
    logic [1:0] seen;

    always #4 core_clk = ~core_clk;

    ortsm_top dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .conv_rise_sample, .conv_fall_sample, .marker_input, .ddc_valid, .ddc_a_i, .ddc_a_q,
        .ddc_b_i, .ddc_b_q, .sysref_in, .chan_a_high_flag_out, .chan_a_low_flag_out,
        .chan_b_high_flag_out, .chan_b_low_flag_out, .out_rise_sample, .out_fall_sample,
        .out_cplx_valid, .out_a_i, .out_a_q, .out_b_i, .out_b_q, .sysref_capture,
        .link_mode_select);
    ortsm_rx_model part (.core_clk, .rst, .sref_en, .single_chan(1'b0),
        .a_hi(chan_a_high_flag_out), .a_lo(chan_a_low_flag_out), .b_hi(chan_b_high_flag_out),
        .b_lo(chan_b_low_flag_out), .sysref_out(sysref_in), .or_hi(), .or_lo(), .gain_up);

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
        compares++;
        if (seen_v !== exp_v) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic conclude();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Stimulus counts reference edges itself; the expectation never comes from the design
    always @(posedge core_clk) begin
        cyc++;
        sref_d <= sysref_in;
        if (sysref_in === 1'b1 && sref_d === 1'b0) rises++;
        if (sysref_capture === 1'b1) caps++;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rd(ORTSM_ADDR_THRESH, d);
        chk(d, 32'h0000_40E4);
        rd(ORTSM_ADDR_OVR_CFG, d);
        chk(d, 32'h0);
        rd(8'h10, d);
        chk(d, 32'h0);
        foreach (rows[i]) begin
            wr(ORTSM_ADDR_CTRL, 32'(rows[i].ctrl));
            conv_rise_sample <= rows[i].rise;
            conv_fall_sample <= rows[i].fall;
            marker_input <= rows[i].mark;
            repeat (5) @(posedge core_clk);
            #1 chk(32'(out_rise_sample), 32'(rows[i].e_rise));
            chk(32'(out_fall_sample), 32'(rows[i].e_fall));
        end
        wr(ORTSM_ADDR_CTRL, 32'h0);
        conv_rise_sample <= 12'h000;
        conv_fall_sample <= 12'h000;
        marker_input <= 1'b0;
        // Threshold boundaries, both signs and the saturating code
        foreach (thr_s[i]) begin
            repeat (14) @(posedge core_clk);
            conv_rise_sample <= thr_s[i];
            seen = 2'h0;
            for (int k = 0; k < 4; k++) begin
                @(posedge core_clk);
                conv_rise_sample <= 12'h000;
                #1 seen = seen | {chan_a_high_flag_out, chan_a_low_flag_out};
            end
            chk(32'(seen), 32'(thr_e[i]));
        end
        for (int h = 0; h < 8; h++) begin
            wr(ORTSM_ADDR_OVR_CFG, 32'(h));
            repeat (12) @(posedge core_clk);
            conv_fall_sample <= 12'h800;
            n = 0;
            for (int k = 0; k < 1100; k++) begin
                @(posedge core_clk);
                conv_fall_sample <= 12'h000;
                #1;
                if ({chan_b_high_flag_out, chan_b_low_flag_out} === 2'h3) n++;
                else if (n > 0) break;
            end
            chk(32'(n), 32'(8 << h));
        end
        wr(ORTSM_ADDR_CTRL, 32'h80);
        repeat (2) @(posedge core_clk);
        chk(32'(link_mode_select), 32'h8);
        // Embedded flags: one low-level hit must mark exactly one window of Q samples
        for (int h = 1; h < 4; h += 2) begin
            wr(ORTSM_ADDR_OVR_CFG, 32'(h));
            repeat (20) @(posedge core_clk);
            conv_rise_sample <= 12'h200;
            {ddc_a_i, ddc_a_q, ddc_b_i, ddc_b_q} <= {4{16'hFFFF}};
            ddc_valid <= 1'b1;
            n = 0;
            m = 0;
            for (int k = 0; k < 40; k++) begin
                @(posedge core_clk);
                conv_rise_sample <= 12'h000;
                #1;
                if (out_cplx_valid === 1'b1 && out_a_q[0] === 1'b1) n++;
                if (out_cplx_valid === 1'b1 && (out_a_i[0] | out_b_i[0] | out_b_q[0]) !== 1'b0) m++;
            end
            chk(32'(n), 32'(1 << h));
            chk(32'(m), 32'h0);
            chk(32'(out_a_q >> 1), 32'h7FFF);
            ddc_valid <= 1'b0;
        end
        wr(ORTSM_ADDR_CTRL, 32'h1);
        repeat (5) @(posedge core_clk);
        marker_input <= 1'b1;
        for (int k = 1; k < 6; k++) begin
            @(posedge core_clk);
            marker_input <= 1'b0;
            #1 chk(32'(out_rise_sample[0]), 32'(k == 3));
        end
        sref_en <= 1'b1;
        repeat (200) @(posedge core_clk);
        sref_en <= 1'b0;
        wr(ORTSM_ADDR_STATUS, 32'hFFFF_FFFF);
        rd(ORTSM_ADDR_STATUS, d);
        chk(32'(d[31:16]), 32'(rises));
        chk(32'(caps), 32'(rises));
        chk(32'(d[8]), 32'h1);
        // Second reset in mid-run
        wr(ORTSM_ADDR_CTRL, 32'h81);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk(32'(link_mode_select), 32'h0);
        rst <= 1'b0;
        rd(ORTSM_ADDR_CTRL, d);
        chk(d, 32'h0);
        repeat (70) @(posedge core_clk);
        chk(32'(gain_up), 32'h1);
        conclude();
    end
endmodule

//--- shared/ortsm_ovr_if.sv
`timescale 1ns/1ps
interface ortsm_ovr_if;
    logic [2:0] overrange_hold_select;
    logic [7:0] high_level_threshold;
    logic [7:0] low_level_threshold;
    logic [11:0] sample;
    logic sample_valid;
    logic pulse_hi;
    logic pulse_lo;
    logic emb_hi;
    logic emb_lo;

    modport mon (
        input overrange_hold_select,
        input high_level_threshold,
        input low_level_threshold,
        input sample,
        input sample_valid,
        output pulse_hi,
        output pulse_lo,
        output emb_hi,
        output emb_lo
    );
    modport ctl (
        output overrange_hold_select,
        output high_level_threshold,
        output low_level_threshold,
        output sample,
        output sample_valid,
        input pulse_hi,
        input pulse_lo,
        input emb_hi,
        input emb_lo
    );
endinterface

//--- shared/ortsm_pkg.sv
package ortsm_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] ORTSM_ADDR_CTRL = 8'h00;
    localparam logic [7:0] ORTSM_ADDR_OVR_CFG = 8'h04;
    localparam logic [7:0] ORTSM_ADDR_THRESH = 8'h08;
    localparam logic [7:0] ORTSM_ADDR_STATUS = 8'h0C;

    // ==========================================================
    // Field positions
    localparam int ORTSM_CTRL_TS_EN_BIT = 0;
    localparam int ORTSM_CTRL_SINGLE_BIT = 1;
    localparam int ORTSM_CTRL_BYTE_BIT = 2;
    localparam int ORTSM_CTRL_MODE_LSB = 4;
    localparam int ORTSM_THR_HI_LSB = 0;
    localparam int ORTSM_THR_LO_LSB = 8;
    localparam int ORTSM_STAT_PULSE_LSB = 0;
    localparam int ORTSM_STAT_EMB_LSB = 4;
    localparam int ORTSM_STAT_TS_BIT = 8;
    localparam int ORTSM_STAT_SREF_LSB = 16;

    // ==========================================================
    // Reset values
    localparam logic [31:0] ORTSM_CTRL_RST = 32'h0000_0000;
    localparam logic [2:0] ORTSM_HOLD_RST = 3'h0;
    localparam logic [7:0] ORTSM_THR_HI_RST = 8'hE4;
    localparam logic [7:0] ORTSM_THR_LO_RST = 8'h40;

    // ==========================================================
    // Timing counts and modes
    localparam int ORTSM_PULSE_BASE = 8;
    localparam int ORTSM_PULSE_W = 11;
    localparam int ORTSM_WIN_W = 8;
    localparam int ORTSM_MARK_LAT = 2;
    localparam logic [3:0] ORTSM_MODE_DECIM_FIRST = 4'h8;

    typedef logic [3:0] ortsm_mode_t;

    // Magnitude for threshold compare; the most negative code saturates
    function automatic logic [7:0] ortsm_abs_top8(input logic [11:0] s);
        logic [10:0] mag;
        mag = 11'h000;
        if (s == 12'h800) begin
            mag = 11'h7FF;
        end else if (s[11]) begin
            mag = 11'((~s) + 12'h001);
        end else begin
            mag = s[10:0];
        end
        return mag[10:3];
    endfunction

    function automatic logic ortsm_mode_decim(input ortsm_mode_t m);
        return m >= ORTSM_MODE_DECIM_FIRST;
    endfunction

endpackage
